// file: common/dscc_map.svh
// constants for the serial dac command control block
`ifndef DSCC_MAP_SVH
`define DSCC_MAP_SVH
`define DSCC_WORD_BITS       24
`define DSCC_CTRL_MSB        23
`define DSCC_CTRL_LSB        16
`define DSCC_CMD_NOP         8'h00
`define DSCC_CMD_SW_LOAD     8'h01
`define DSCC_CMD_CLEAR       8'h02
`define DSCC_CMD_POWER       8'h03
`define DSCC_CMD_LIN         8'h05
`define DSCC_CMD_NOP2        8'h20
`define DSCC_OP_WRITE        4'h1
`define DSCC_OP_WTHRU        4'h3
`define DSCC_BIT_D8          8
`define DSCC_BIT_D7          7
`define DSCC_BIT_LIN         9
`define DSCC_CODE_ZERO       16'h0000
`define DSCC_CODE_MID        16'h8000
`define DSCC_MASK12          16'hFFF0
`define DSCC_MASK16          16'hFFFF
`endif

// file: common/dscc_pkg.sv
// types shared by the serial dac command control block
package dscc_pkg;
	typedef struct packed {
		logic [7:0]  ctrl; // control field
		logic [15:0] data; // data field
	} dscc_word_t;
	typedef struct packed {
		logic        cs_n; // chip select, active low
		logic        sclk; // serial clock
		logic        din;  // serial data in
	} dscc_serial_t;
endpackage

// file: logic/dscc_sync.sv
// two-flop synchroniser bank for the serial pins
module dscc_sync
	import dscc_pkg::*;
(
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// raw and synchronised pins
	input  wire dscc_serial_t pin_in,
	output      dscc_serial_t pin_out
);
	dscc_serial_t meta_r; // first stage, read only by second stage

	// chip select idles high so reset to the inactive level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r  <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
			pin_out <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
		end else begin
			meta_r  <= pin_in;
			pin_out <= meta_r;
		end
	end
endmodule // dscc_sync

// file: logic/dscc_ctrl.sv
// serial command decoder with input and dac registers
`include "dscc_map.svh"

// Notes on behaviour
// - one 24-bit word per chip select frame
// - 8 control bits then 16 data, msb first
// - sample data on each serial clock fall
// - after 24 bits decode and execute command
// - serial clock idle level does not matter
// - stop capturing bits after a full word
// - power-up code zero or midscale from select
// - low load strobe copies input to dac
// - code 0001 writes input register only
// - code 0011 writes input and dac registers
// - command 01 with d8 loads dac
// - command 03 sets power-down and ready enable
// - output changes only on strobe, load, writethrough, clear
// - 16-bit variant holds plain unsigned code
// - 12-bit variant ignores four low bits
// - command 02 restores all power-on defaults
// - chain flag goes low after 24 clocks
// - short frame discarded, registers unchanged
module dscc_ctrl
	import dscc_pkg::*;
#(
	parameter bit TWELVE_BIT = 1'b0 // 1 selects the 12-bit variant
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// serial pins from the host
	input  wire logic        cs_n,
	input  wire logic        sclk,
	input  wire logic        din,
	// static and strobe pins
	input  wire logic        level_select,
	input  wire logic        load_output_strobe_n,
	// chain flag output
	output      logic        ready_n,
	// converter state
	output      logic [15:0] dac_code,
	output      logic [15:0] input_code,
	output      logic        power_down,
	output      logic        ready_enable,
	output      logic        linearity,
	output      logic        word_done
);
	dscc_serial_t raw_s;      // pins grouped for the synchroniser
	dscc_serial_t sync_s;     // synchronised pins
	logic         sclk_d_r;   // previous synchronised clock
	logic         cs_d_r;     // previous synchronised chip select
	logic [23:0]  shift_r;    // serial shift register
	logic [4:0]   count_r;    // bits taken in this frame
	logic         armed_r;    // input buffers enabled
	logic         exec_r;     // one-cycle decode pulse
	logic         lvl_r;      // level select, two-flop
	logic         lvl_meta_r; // level select first stage
	logic         ld_r;       // load strobe, two-flop
	logic         ld_meta_r;  // load strobe first stage
	logic [1:0]   init_r;     // counts down until the level pin has passed both flops
	dscc_word_t   word;       // decoded view of the shift register
	logic         sclk_fall;  // falling serial clock edge
	logic         cs_fall;    // frame start
	logic         cs_rise;    // frame end

	// masks the low nibble for the 12-bit variant
	function automatic logic [15:0] fmt_code(input logic [15:0] d);
		fmt_code = TWELVE_BIT ? (d & `DSCC_MASK12) : (d & `DSCC_MASK16);
	endfunction

	// reset code chosen by the level select pin
	function automatic logic [15:0] reset_code(input logic lvl);
		reset_code = lvl ? `DSCC_CODE_MID : `DSCC_CODE_ZERO;
	endfunction

	assign raw_s = '{cs_n: cs_n, sclk: sclk, din: din};

	dscc_sync u_sync (
		.clk     (clk),
		.rst     (rst),
		.pin_in  (raw_s),
		.pin_out (sync_s)
	);

	// slow static pins get their own synchronisers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lvl_meta_r <= 1'b0;
			lvl_r      <= 1'b0;
			ld_meta_r  <= 1'b1;
			ld_r       <= 1'b1;
		end else begin
			lvl_meta_r <= level_select;
			lvl_r      <= lvl_meta_r;
			ld_meta_r  <= load_output_strobe_n;
			ld_r       <= ld_meta_r;
		end
	end

	// edge history of the synchronised serial pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_d_r <= 1'b0;
			cs_d_r   <= 1'b1;
		end else begin
			sclk_d_r <= sync_s.sclk;
			cs_d_r   <= sync_s.cs_n;
		end
	end

	// only falls while selected count, so the idle level is irrelevant
	assign sclk_fall = sclk_d_r & ~sync_s.sclk & ~sync_s.cs_n;
	assign cs_fall   = cs_d_r & ~sync_s.cs_n;
	assign cs_rise   = ~cs_d_r & sync_s.cs_n;
	assign word      = dscc_word_t'(shift_r);

	// shift register and bit counter; a clock fall in the same cycle as
	// the chip select fall is too close to the frame start to be valid
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_r <= 24'h00_0000;
			count_r <= 5'h00;
			armed_r <= 1'b0;
			exec_r  <= 1'b0;
		end else begin
			exec_r <= 1'b0;
			if (cs_fall) begin
				count_r <= 5'h00;
				armed_r <= 1'b1;
			end else if (cs_rise) begin
				armed_r <= 1'b0;
			end else if (armed_r && sclk_fall) begin
				shift_r <= {shift_r[22:0], sync_s.din};
				count_r <= count_r + 5'h01;
				if (count_r == 5'(`DSCC_WORD_BITS - 1)) begin
					armed_r <= 1'b0;
					exec_r  <= 1'b1;
				end
			end
		end
	end

	// chain flag: low after a full word, while ready enable is set, until chip select rises
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready_n   <= 1'b1;
			word_done <= 1'b0;
		end else begin
			word_done <= exec_r;
			if (cs_rise || cs_fall) begin
				ready_n <= 1'b1;
			end else if (armed_r && sclk_fall && count_r == 5'(`DSCC_WORD_BITS - 1) && ready_enable) begin
				ready_n <= 1'b0;
			end
		end
	end

	// power-up default is applied once the level pin is synchronised;
	// reading the first flop instead would risk a metastable reset code,
	// so the default waits until the second flop holds the pin level
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			init_r <= 2'b11;
		end else if (init_r != 2'b00) begin
			init_r <= init_r - 2'b01;
		end
	end

	// command execution and register file
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			input_code   <= `DSCC_CODE_ZERO;
			dac_code     <= `DSCC_CODE_ZERO;
			power_down   <= 1'b0;
			ready_enable <= 1'b1;
			linearity    <= 1'b0;
		end else if (init_r != 2'b00) begin
			// commands cannot arrive this early, so nothing is lost here
			if (init_r == 2'b01) begin
				dac_code <= reset_code(lvl_r);
			end
		end else if (exec_r) begin
			if (word.ctrl[7:4] == `DSCC_OP_WRITE) begin
				input_code <= fmt_code(word.data);
				if (!ld_r) begin
					dac_code <= fmt_code(word.data);
				end
			end else if (word.ctrl[7:4] == `DSCC_OP_WTHRU) begin
				input_code <= fmt_code(word.data);
				dac_code   <= fmt_code(word.data);
			end else if (word.ctrl == `DSCC_CMD_SW_LOAD) begin
				if (word.data[`DSCC_BIT_D8]) begin
					dac_code <= input_code;
				end
			end else if (word.ctrl == `DSCC_CMD_CLEAR) begin
				input_code   <= `DSCC_CODE_ZERO;
				dac_code     <= reset_code(lvl_r);
				power_down   <= 1'b0;
				ready_enable <= 1'b1;
				linearity    <= 1'b0;
			end else if (word.ctrl == `DSCC_CMD_POWER) begin
				power_down   <= word.data[`DSCC_BIT_D8];
				ready_enable <= word.data[`DSCC_BIT_D7];
			end else if (word.ctrl == `DSCC_CMD_LIN) begin
				linearity <= word.data[`DSCC_BIT_LIN];
			end
			// nop codes and anything unassigned fall through untouched
		end else if (!ld_r) begin
			dac_code <= input_code;
		end
	end
endmodule // dscc_ctrl

// file: sim/dscc_ctrl_checker.sv
// port assertions for the serial dac command control block
module dscc_ctrl_checker
	import dscc_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// pins from the host side
	input wire logic        cs_n,
	input wire logic        level_select,
	input wire logic        load_output_strobe_n,
	// converter state
	input wire logic        ready_n,
	input wire logic [15:0] dac_code,
	input wire logic [15:0] input_code,
	input wire logic        power_down,
	input wire logic        ready_enable,
	input wire logic        linearity,
	input wire logic        word_done
);
	logic [2:0] settle_r; // cycles since reset, saturating

	// the power-up default moves the dac code without a word, so skip it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_r <= 3'h0;
		end else if (settle_r != 3'h7) begin
			settle_r <= settle_r + 3'h1;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// four samples cover the strobe synchroniser delay
	sequence s_strobe; !load_output_strobe_n [*4]; endsequence
	sequence s_quiet; load_output_strobe_n [*4]; endsequence
	property p_strobe; s_strobe |=> dac_code == input_code; endproperty
	a_strobe: assert property (p_strobe) else $error("dac code not following strobe");
	property p_quiet; s_quiet ##1 (!$stable(dac_code) && settle_r == 3'h7) |-> word_done; endproperty
	a_quiet: assert property (p_quiet) else $error("dac code moved without a load");
	property p_inhold; !$stable(input_code) |-> word_done; endproperty
	a_inhold: assert property (p_inhold) else $error("input code moved without a word");
	property p_state; !$stable({power_down, ready_enable, linearity}) |-> word_done; endproperty
	a_state: assert property (p_state) else $error("state moved without a word");
	property p_rdy_cause; $fell(ready_n) |-> $past(ready_enable) && !cs_n; endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("chain flag fell without cause");
	property p_rdy_done; word_done && $past(ready_enable, 2) |-> !ready_n; endproperty
	a_rdy_done: assert property (p_rdy_done) else $error("chain flag high at word end");
	property p_rdy_free; $rose(cs_n) |-> ##[0:5] ready_n; endproperty
	a_rdy_free: assert property (p_rdy_free) else $error("chain flag stuck after frame");
	property p_rdy_hold; !ready_n && !cs_n |=> !ready_n; endproperty
	a_rdy_hold: assert property (p_rdy_hold) else $error("chain flag left early");
	property p_reset; $fell(rst) |-> ##3 dac_code == (level_select ? 16'h8000 : 16'h0000); endproperty
	a_reset: assert property (p_reset) else $error("wrong power-up code");
endmodule // dscc_ctrl_checker

bind dscc_ctrl dscc_ctrl_checker dscc_ctrl_checker_i (.*);

// file: sim/dscc_host.sv
// serial host model that frames words onto the converter pins
module dscc_host
	import dscc_pkg::*;
(
	// clock
	input wire logic clk,
	// serial pins
	output dscc_serial_t pin
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pin = 3'b100;
	// serial clock idles still outside frames; four clk per half gives 200 ns
	task send(input logic [23:0] w, input int n, input logic idle);
		pin.sclk <= idle;
		pin.cs_n <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < n; i++) begin
			pin.din <= (i < 24) ? w[23 - i] : 1'b1;
			pin.sclk <= 1'b1;
			repeat (4) @(posedge clk);
			pin.sclk <= 1'b0;
			repeat (4) @(posedge clk);
		end
		// released data line shows the inverse so a stale bit is never trusted
		pin.din <= ~pin.din;
		repeat (8) @(posedge clk);
		pin.cs_n <= 1'b1;
		pin.sclk <= idle;
		repeat (8) @(posedge clk);
	endtask
endmodule // dscc_host

// file: sim/test_dscc_ctrl.sv
// testbench for the serial dac command control block
module test_dscc_ctrl import dscc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, level_select = 1, load_output_strobe_n = 1;
	logic ready_n, power_down, ready_enable, linearity, word_done;
	logic [15:0] dac_code, input_code, in12_code;
	dscc_serial_t pin;
	int fails = 0, tests_run = 0;
	logic [7:0] nops [4] = '{8'h00, 8'h20, 8'h7F, 8'h04};
	always #12.5 clk = ~clk;
	dscc_host dscc_host_i (.clk(clk), .pin(pin));
	dscc_ctrl dscc_ctrl_i (.clk(clk), .rst(rst), .cs_n(pin.cs_n), .sclk(pin.sclk), .din(pin.din),
		.level_select(level_select), .load_output_strobe_n(load_output_strobe_n), .ready_n(ready_n),
		.dac_code(dac_code), .input_code(input_code), .power_down(power_down),
		.ready_enable(ready_enable), .linearity(linearity), .word_done(word_done));
	// 12-bit variant on the same pins, only its input register is watched
	dscc_ctrl #(.TWELVE_BIT(1'b1)) dscc_ctrl_12_i (.clk(clk), .rst(rst), .cs_n(pin.cs_n), .sclk(pin.sclk),
		.din(pin.din), .level_select(level_select), .load_output_strobe_n(load_output_strobe_n),
		.ready_n(), .dac_code(), .input_code(in12_code), .power_down(), .ready_enable(), .linearity(),
		.word_done());
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			$display("unexpected %s exp %h got %h", n, e, g);
			fails++;
		end
	endtask
	task results;
		$display("fails %0d tests_run %0d", fails, tests_run);
		if (fails == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task cmd(input logic [23:0] w, input int n = 24, input logic idle = 0);
		dscc_host_i.send(w, n, idle);
	endtask
	// watchdog against a hung run
	initial begin
		repeat (60000) @(posedge clk);
		fails++;
		results;
	end
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		repeat (8) @(posedge clk);
		chk("reset dac", 16'h8000, dac_code);
		cmd(24'h10_1234, 24, 1);
		chk("write in", 16'h1234, input_code);
		chk("write in 12", 16'h1230, in12_code);
		chk("write dac", 16'h8000, dac_code);
		cmd(24'h01_0000);
		chk("load off", 16'h8000, dac_code);
		cmd(24'h01_0100);
		chk("load on", 16'h1234, dac_code);
		$display("write and load done");
		cmd(24'h10_FFFF, 10);
		chk("short frame", 16'h1234, input_code);
		cmd(24'h30_5678, 26);
		chk("thru in", 16'h5678, input_code);
		chk("thru dac", 16'h5678, dac_code);
		cmd(24'h10_9ABC);
		load_output_strobe_n <= 0;
		repeat (6) @(posedge clk);
		load_output_strobe_n <= 1;
		repeat (4) @(posedge clk);
		chk("strobe dac", 16'h9ABC, dac_code);
		$display("frame and strobe done");
		foreach (nops[k]) begin
			cmd({nops[k], 16'hFFFF});
			chk("nop dac", 16'h9ABC, dac_code);
			chk("nop in", 16'h9ABC, input_code);
		end
		cmd(24'h05_0200);
		chk("lin on", 16'h0003, 16'({power_down, ready_enable, linearity}));
		cmd(24'h05_0000);
		chk("lin off", 16'h0002, 16'({power_down, ready_enable, linearity}));
		cmd(24'h03_0100);
		chk("power", 16'h0004, 16'({power_down, ready_enable, linearity}));
		cmd(24'h02_0000);
		chk("clear flags", 16'h0002, 16'({power_down, ready_enable, linearity}));
		chk("clear in", 16'h0000, input_code);
		chk("clear dac", 16'h8000, dac_code);
		$display("commands done");
		// second reset with the select low
		rst <= 1;
		level_select <= 0;
		repeat (4) @(posedge clk);
		rst <= 0;
		repeat (8) @(posedge clk);
		chk("zero dac", 16'h0000, dac_code);
		$display("reset level done");
		results;
	end
endmodule // test_dscc_ctrl
